// ---- design/clc_pkg.sv ----
// Constants, types and register map of the channel limit checker
package clc_pkg;
  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NCH = 4; // Channels
  localparam int CNT_W = 16; // Reading counter width
  typedef logic signed [7:0] clc_code_t; // Limit or sample in range steps
  typedef logic [2:0] clc_idx_t; // Limit memory index {chan, upper}

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [7:0] A_CTRL = 8'h00; // Mode and range
  localparam logic [7:0] A_CMD = 8'h04; // Abort command
  localparam logic [7:0] A_STAT = 8'h08; // Activity status
  localparam logic [7:0] A_ERR = 8'h0c; // Error flags, write one clears
  localparam logic [7:0] A_QUES = 8'h10; // Questionable data, masked
  localparam logic [7:0] A_QMASK = 8'h14; // Questionable data mask
  localparam logic [7:0] A_COUNT = 8'h18; // Readings taken
  localparam logic [7:0] A_LIM_BASE = 8'h20; // Limits, 8 words
  localparam logic [7:0] A_LIM_MASK = 8'he0; // Limit window decode
  localparam logic [7:0] A_EN_BASE = 8'h40; // Enables, 4 words
  localparam logic [7:0] A_EN_MASK = 8'hf0; // Enable window decode

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_CONT = 1; // Continuous measurement
  localparam int CTRL_CALEN = 2; // Calibration enable
  localparam int CTRL_RNG = 4; // Range, 3 bits
  localparam int CTRL_TRG = 7; // Internal level trigger selected
  localparam int CTRL_TCH = 8; // Trigger channel, 2 bits
  localparam int CMD_ABORT = 0; // Abort strobe
  localparam int STAT_MEAS = 0; // Measurement running
  localparam int STAT_CONT = 1; // Continuous mode on
  localparam int STAT_CAL = 2; // Calibration running
  localparam int STAT_CALEN = 3; // Calibration enabled
  localparam int ERR_LIM = 0; // Limit outside range bound
  localparam int ERR_TRG = 1; // Enable conflicts with trigger
  localparam int QUES_LO = 9; // Lower limit failure
  localparam int QUES_UP = 10; // Upper limit failure
  localparam int EN_LO = 0; // Lower check enable
  localparam int EN_UP = 1; // Upper check enable
  localparam int EN_FAIL = 2; // Fail flag of last measurement

  // ************************************************************
  // Values
  // ************************************************************
  localparam clc_code_t LIM_LO_MAX = 8'h7e; // Lower bound in steps
  localparam clc_code_t LIM_UP_MAX = 8'h7f; // Upper bound in steps
  localparam clc_code_t LO_RST = 8'h81; // Lower reset, -254 V
  localparam clc_code_t UP_RST = 8'h7e; // Upper reset, +252 V
  localparam logic [2:0] RNG_RST = 3'h6; // Largest range
  localparam logic [1:0] RESP_OKAY = 2'h0; // Bus response

  // Bus slave phase
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_RESP = 2'b10
  } clc_bus_e;
endpackage

// ---- design/clc_lim_if.sv ----
// Port bundle between the checker and its limit memory
`timescale 1ns/10ps
interface clc_lim_if;
  import clc_pkg::*;
  logic we; // Write strobe
  clc_idx_t waddr; // Write index
  clc_code_t wdata; // Write value
  clc_idx_t raddr_a; // Bus read index
  clc_code_t rdata_a; // Bus read value, registered
  clc_idx_t raddr_b; // Compare read index
  clc_code_t rdata_b; // Compare read value, registered
  modport ctl (output we, waddr, wdata, raddr_a, raddr_b,
    input rdata_a, rdata_b);
  modport mem (input we, waddr, wdata, raddr_a, raddr_b,
    output rdata_a, rdata_b);
endinterface

// ---- design/clc_lim_mem.sv ----
// Limit value memory, one write and two registered read ports
`timescale 1ns/10ps
module clc_lim_mem
  import clc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  clc_lim_if.mem lim
);
  // Words, even index lower limit, odd index upper limit
  typedef struct packed {
    clc_code_t [7:0] word;
    clc_code_t rd_a;
    clc_code_t rd_b;
  } clc_mem_s;

  // Reset loads LO_RST lower and UP_RST upper limit per channel
  localparam clc_mem_s MEM_RST = '{word: {4{UP_RST, LO_RST}},
    default: '0};

  clc_mem_s st_q; // State
  clc_mem_s st_d; // Next state

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    st_d = st_q;
    // Write port
    if (lim.we)
    begin
      st_d.word[lim.waddr] = lim.wdata;
    end
    st_d.rd_a = st_q.word[lim.raddr_a];
    st_d.rd_b = st_q.word[lim.raddr_b];
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= MEM_RST;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  assign lim.rdata_a = st_q.rd_a;
  assign lim.rdata_b = st_q.rd_b;
endmodule

// ---- design/clc_cmp.sv ----
// Sample against limit comparator with registered hit vectors
`timescale 1ns/10ps
module clc_cmp
  import clc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic vld,
  input wire logic [1:0] ch,
  input wire logic up,
  input clc_pkg::clc_code_t code,
  input clc_pkg::clc_code_t lim,
  output logic [NCH-1:0] hit_lo,
  output logic [NCH-1:0] hit_up
);
  // Hit vectors, one bit per channel
  typedef struct packed {
    logic [NCH-1:0] lo;
    logic [NCH-1:0] up;
  } clc_cmp_s;

  clc_cmp_s st_q; // State
  clc_cmp_s st_d; // Next state

  // ************************************************************
  // Compare
  // ************************************************************
  always_comb
  begin
    st_d = '0;
    if (vld && up && (code > lim))
    begin
      st_d.up[ch] = 1'b1;
    end
    else if (vld && !up && (code < lim))
    begin
      st_d.lo[ch] = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= '0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  assign hit_lo = st_q.lo;
  assign hit_up = st_q.up;
endmodule

// ---- design/clc_top.sv ----
// Channel limit checker with abort control and register slave
//
// Contract
// - Abort ends running and continuous measurement
// - Abort while idle raises no error, only clears continuous mode and calibration enable
// - Abort ends calibration, clears calibration enable
// - Reading count survives abort, stays readable
// - Abort keeps settings, accepted while initiated
// - Enabling one check disables the other
// - Per channel fail flag readable, 1 failed
// - Fail flag cleared at each measurement start
// - Lower check fails when input below limit
// - Upper check fails when input above limit
// - Failures shown in status bits 9, 10, maskable
// - Lower limit quantized, bounded per range
// - Upper limit quantized, bounded per range
// - Limit beyond range bound flags an error
// - Range change keeps limit fraction of scale
// - Enable on level trigger channel is rejected
// - Enable state reads 1 on, 0 off
// - Limits and enables held per channel
`timescale 1ns/10ps
module clc_top
  import clc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic meas_start,
  input wire logic meas_end,
  input wire logic samp_valid,
  input wire logic [1:0] samp_chan,
  input clc_pkg::clc_code_t samp_code,
  input wire logic cal_start,
  input wire logic cal_done,
  output logic meas_active,
  output logic cal_active
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    clc_bus_e ph; // Bus phase
    logic [7:0] addr; // Latched address
    logic wr; // Latched direction
    logic [31:0] rdata; // Read data
    logic ready; // Ready out
    logic meas; // Measurement running
    logic cont; // Continuous mode
    logic cal_en; // Calibration enable
    logic cal_run; // Calibration running
    logic [2:0] rng; // Input range
    logic trg_int; // Internal level trigger selected
    logic [1:0] trg_ch; // Level trigger channel
    logic [NCH-1:0] lo_en; // Lower checks
    logic [NCH-1:0] up_en; // Upper checks
    logic [NCH-1:0] f_lo; // Lower fail flags
    logic [NCH-1:0] f_up; // Upper fail flags
    logic err_lim; // Limit bound error
    logic err_trg; // Trigger conflict error
    logic [1:0] qmask; // Questionable mask
    logic [CNT_W-1:0] count; // Readings taken
    logic s_vld; // Sample stage valid
    logic [1:0] s_ch; // Sample channel
    clc_code_t s_code; // Sample value
    logic s_up; // Sample checks upper limit
  } clc_st_s;

  // Reset value, checks off, largest range
  localparam clc_st_s ST_RST = '{ph: BUS_IDLE, ready: 1'b1,
    rng: RNG_RST, default: '0};

  clc_st_s st_q; // State
  clc_st_s st_d; // Next state
  logic accept; // Address phase taken
  logic abort_req; // Abort written
  logic lim_bad; // Limit write out of bound
  logic en_conflict; // Enable write refused
  logic new_meas; // A measurement begins
  logic [NCH-1:0] hit_lo; // Lower hits from comparator
  logic [NCH-1:0] hit_up; // Upper hits from comparator
  clc_lim_if lim (); // Limit memory port

  // ************************************************************
  // Functions
  // ************************************************************
  // Code within the bound of the current range
  function automatic logic lim_ok(input clc_code_t c, input logic up);
    clc_code_t mx;
    mx = up ? LIM_UP_MAX : LIM_LO_MAX;
    return (c <= mx) && (c >= -mx);
  endfunction

  // Channel feeds the internal level trigger
  function automatic logic trg_busy(input clc_st_s s,
    input logic [1:0] ch);
    return s.trg_int && (s.trg_ch == ch);
  endfunction

  // ************************************************************
  // Submodules
  // ************************************************************
  clc_lim_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .lim(lim.mem)
  );

  clc_cmp u_cmp (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .vld(st_q.s_vld),
    .ch(st_q.s_ch),
    .up(st_q.s_up),
    .code(st_q.s_code),
    .lim(lim.rdata_b),
    .hit_lo(hit_lo),
    .hit_up(hit_up)
  );

  // Memory read indices follow the address phase and the sample
  assign accept = hsel && htrans[1] && hready;
  assign lim.raddr_a = haddr[4:2];
  assign lim.raddr_b = {samp_chan, st_q.up_en[samp_chan]};

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    st_d = st_q;
    abort_req = 1'b0;
    lim_bad = 1'b0;
    en_conflict = 1'b0;
    lim.we = 1'b0;
    lim.waddr = st_q.addr[4:2];
    lim.wdata = hwdata[7:0];
    new_meas = 1'b0;
    // Bus slave, one wait cycle in every data phase
    case (st_q.ph)
      BUS_IDLE, BUS_RESP:
      begin
        st_d.ph = BUS_IDLE;
        st_d.ready = 1'b1;
        if (accept)
        begin
          st_d.ph = BUS_WAIT;
          st_d.addr = haddr[7:0];
          st_d.wr = hwrite;
          st_d.ready = 1'b0;
        end
      end
      BUS_WAIT:
      begin
        st_d.ph = BUS_RESP;
        st_d.ready = 1'b1;
        st_d.rdata = '0;
        if (st_q.wr)
        begin
          // Register writes
          if (st_q.addr == A_CTRL)
          begin
            // Range change leaves codes, so volts rescale
            st_d.cont = hwdata[CTRL_CONT];
            st_d.cal_en = hwdata[CTRL_CALEN];
            st_d.rng = hwdata[CTRL_RNG +: 3];
            st_d.trg_int = hwdata[CTRL_TRG];
            st_d.trg_ch = hwdata[CTRL_TCH +: 2];
          end
          else if (st_q.addr == A_CMD)
          begin
            abort_req = hwdata[CMD_ABORT];
          end
          else if (st_q.addr == A_ERR)
          begin
            // Write one clears
            if (hwdata[ERR_LIM])
            begin
              st_d.err_lim = 1'b0;
            end
            if (hwdata[ERR_TRG])
            begin
              st_d.err_trg = 1'b0;
            end
          end
          else if (st_q.addr == A_QMASK)
          begin
            st_d.qmask = hwdata[QUES_UP:QUES_LO];
          end
          else if ((st_q.addr & A_LIM_MASK) == A_LIM_BASE)
          begin
            // Store in range steps, refuse beyond bound
            if (lim_ok(hwdata[7:0], st_q.addr[2]))
            begin
              lim.we = 1'b1;
            end
            else
            begin
              lim_bad = 1'b1;
              st_d.err_lim = 1'b1;
            end
          end
          else if ((st_q.addr & A_EN_MASK) == A_EN_BASE)
          begin
            // Enables, at most one per channel
            if ((hwdata[EN_LO] || hwdata[EN_UP])
              && trg_busy(st_q, st_q.addr[3:2]))
            begin
              en_conflict = 1'b1;
              st_d.err_trg = 1'b1;
            end
            else
            begin
              st_d.up_en[st_q.addr[3:2]] = hwdata[EN_UP];
              st_d.lo_en[st_q.addr[3:2]] = hwdata[EN_LO]
                && !hwdata[EN_UP];
            end
          end
        end
        else
        begin
          // Register reads, unmapped reads give zero
          if (st_q.addr == A_CTRL)
          begin
            st_d.rdata[CTRL_CONT] = st_q.cont;
            st_d.rdata[CTRL_CALEN] = st_q.cal_en;
            st_d.rdata[CTRL_RNG +: 3] = st_q.rng;
            st_d.rdata[CTRL_TRG] = st_q.trg_int;
            st_d.rdata[CTRL_TCH +: 2] = st_q.trg_ch;
          end
          else if (st_q.addr == A_STAT)
          begin
            st_d.rdata[STAT_MEAS] = st_q.meas;
            st_d.rdata[STAT_CONT] = st_q.cont;
            st_d.rdata[STAT_CAL] = st_q.cal_run;
            st_d.rdata[STAT_CALEN] = st_q.cal_en;
          end
          else if (st_q.addr == A_ERR)
          begin
            st_d.rdata[ERR_LIM] = st_q.err_lim;
            st_d.rdata[ERR_TRG] = st_q.err_trg;
          end
          else if (st_q.addr == A_QUES)
          begin
            st_d.rdata[QUES_LO] = (|st_q.f_lo) && st_q.qmask[0];
            st_d.rdata[QUES_UP] = (|st_q.f_up) && st_q.qmask[1];
          end
          else if (st_q.addr == A_QMASK)
          begin
            st_d.rdata[QUES_UP:QUES_LO] = st_q.qmask;
          end
          else if (st_q.addr == A_COUNT)
          begin
            st_d.rdata[CNT_W-1:0] = st_q.count;
          end
          else if ((st_q.addr & A_LIM_MASK) == A_LIM_BASE)
          begin
            st_d.rdata[7:0] = lim.rdata_a;
          end
          else if ((st_q.addr & A_EN_MASK) == A_EN_BASE)
          begin
            st_d.rdata[EN_LO] = st_q.lo_en[st_q.addr[3:2]];
            st_d.rdata[EN_UP] = st_q.up_en[st_q.addr[3:2]];
            st_d.rdata[EN_FAIL] = st_q.f_lo[st_q.addr[3:2]]
              || st_q.f_up[st_q.addr[3:2]];
          end
        end
      end
      default:
      begin
        st_d.ph = BUS_IDLE;
        st_d.ready = 1'b1;
      end
    endcase

    // Measurement sequencing, abort wins over a start in the same cycle
    new_meas = !abort_req && ((meas_start && !st_q.meas)
      || (meas_end && st_q.meas && st_q.cont));
    if (meas_start && !st_q.meas && !abort_req)
    begin
      st_d.meas = 1'b1;
      st_d.count = '0;
    end
    if (meas_end && st_q.meas && !st_q.cont)
    begin
      st_d.meas = 1'b0;
    end
    if (samp_valid && st_q.meas)
    begin
      st_d.count = st_q.count + 16'h0001;
    end
    // Fail flags restart per measurement, a hit wins
    if (new_meas)
    begin
      st_d.f_lo = '0;
      st_d.f_up = '0;
    end
    st_d.f_lo = st_d.f_lo | hit_lo;
    st_d.f_up = st_d.f_up | hit_up;

    // Sample stage toward the comparator
    st_d.s_vld = samp_valid && st_q.meas
      && (st_q.lo_en[samp_chan] || st_q.up_en[samp_chan]);
    st_d.s_ch = samp_chan;
    st_d.s_code = samp_code;
    st_d.s_up = st_q.up_en[samp_chan];

    // Calibration run, a start beats a done in the same cycle
    if (cal_done)
    begin
      st_d.cal_run = 1'b0;
    end
    if (cal_start && st_q.cal_en)
    begin
      st_d.cal_run = 1'b1;
    end

    // Abort stops activity, clears continuous mode and calibration enable, other settings and count kept
    if (abort_req)
    begin
      st_d.meas = 1'b0;
      st_d.cont = 1'b0;
      st_d.s_vld = 1'b0;
      st_d.cal_run = 1'b0;
      st_d.cal_en = 1'b0;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= ST_RST;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state, hresp fixed at RESP_OKAY
  assign hrdata = st_q.rdata;
  assign hreadyout = st_q.ready;
  assign hresp = RESP_OKAY;
  assign meas_active = st_q.meas;
  assign cal_active = st_q.cal_run;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_acc;
    clk_en && accept && (st_q.ph != BUS_WAIT);
  endsequence
  sequence s_wait;
    !hreadyout && clk_en;
  endsequence

  bus_wait_a: assert property (s_acc |=> !hreadyout)
    else $error("data phase not stretched");
  bus_resp_a: assert property (s_wait |=> hreadyout)
    else $error("data phase too long");
  abort_stops_a: assert property (clk_en && abort_req |=>
    !st_q.meas && !st_q.cont && !meas_active)
    else $error("abort left measurement running");
  abort_quiet_a: assert property (clk_en && abort_req && !st_q.meas
    |=> $stable(st_q.err_lim) && $stable(st_q.err_trg))
    else $error("idle abort raised error");
  abort_cal_a: assert property (clk_en && abort_req |=>
    !st_q.cal_en && !cal_active)
    else $error("abort left calibration on");
  count_kept_a: assert property (clk_en && abort_req && !samp_valid
    |=> st_q.count == $past(st_q.count))
    else $error("abort changed reading count");
  cfg_kept_a: assert property (clk_en && abort_req |=>
    $stable(st_q.rng) && $stable(st_q.lo_en))
    else $error("abort changed settings");
  one_check_a: assert property ((st_q.lo_en & st_q.up_en) == '0)
    else $error("both checks enabled");
  fail_clear_a: assert property (clk_en && new_meas && !(|hit_lo)
    && !(|hit_up) |=> (st_q.f_lo | st_q.f_up) == '0)
    else $error("fail flag not cleared");
  lo_fail_a: assert property (clk_en && (|hit_lo) |=>
    (st_q.f_lo & $past(hit_lo)) == $past(hit_lo))
    else $error("lower failure lost");
  lim_err_a: assert property (clk_en && lim_bad |=>
    st_q.err_lim)
    else $error("bound error not flagged");
  trg_err_a: assert property (clk_en && en_conflict |=> st_q.err_trg
    && $stable(st_q.lo_en) && $stable(st_q.up_en))
    else $error("trigger conflict accepted");
endmodule

// ---- sim/clc_top_bench.sv ----
// Self-checking bench of the channel limit checker
`timescale 1ns/10ps
module clc_top_bench;
  import clc_pkg::*;
  // ************************************************************
  // Stimulus and observed signals
  // ************************************************************
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic [1:0] htrans = 2'h0, hresp, samp_chan = 2'h0;
  logic hreadyout, meas_active, cal_active, cal_start = 1'b0;
  logic meas_start = 1'b0, meas_end = 1'b0, samp_valid = 1'b0;
  clc_code_t samp_code = 8'h00; // Reading in steps
  int mismatches = 0;
  int checks_done = 0;

  clc_top i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_start(meas_start),
    .meas_end(meas_end), .samp_valid(samp_valid), .samp_chan(samp_chan),
    .samp_code(samp_code), .cal_start(cal_start), .cal_done(1'b0),
    .meas_active(meas_active), .cal_active(cal_active));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Compare and count
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One AHB single word transfer, waits on hready both phases
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, rdv, e);
  endtask
  // Start or end pulse of a measurement
  task pm(input logic s);
    @(posedge hclk);
    meas_start <= s;
    meas_end <= !s;
    @(posedge hclk);
    meas_start <= 1'b0;
    meas_end <= 1'b0;
  endtask
  // One reading on a channel
  task smp(input logic [1:0] c, input clc_code_t v);
    @(posedge hclk);
    samp_valid <= 1'b1;
    samp_chan <= c;
    samp_code <= v;
    @(posedge hclk);
    samp_valid <= 1'b0;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset values of limits, enables and range
  task t_reset;
    for (int c = 0; c < NCH; c++)
    begin
      rdc("en", A_EN_BASE + 8'(4 * c), 32'h0);
      rdc("lo", A_LIM_BASE + 8'(8 * c), 32'h81);
      rdc("up", A_LIM_BASE + 8'(8 * c + 4), 32'h7e);
    end
    rdc("ctrl", A_CTRL, 32'h60);
    chk("resp", {30'h0, hresp}, 32'h0);
  endtask
  // Exclusive enables, per channel storage, limit bounds
  task t_excl;
    wr(A_EN_BASE + 8'h4, 32'h1);
    rdc("en1", A_EN_BASE + 8'h4, 32'h1);
    wr(A_EN_BASE + 8'h4, 32'h2);
    rdc("en1", A_EN_BASE + 8'h4, 32'h2);
    rdc("en2", A_EN_BASE + 8'h8, 32'h0);
    wr(A_LIM_BASE + 8'hc, 32'h3);
    rdc("up1", A_LIM_BASE + 8'hc, 32'h3);
    rdc("up0", A_LIM_BASE + 8'h4, 32'h7e);
    wr(A_LIM_BASE, 32'h7f);
    rdc("lo0", A_LIM_BASE, 32'h81);
    rdc("err", A_ERR, 32'h1);
    wr(A_ERR, 32'h3);
    wr(A_LIM_BASE + 8'h4, 32'h80);
    rdc("up0", A_LIM_BASE + 8'h4, 32'h7e);
    rdc("err", A_ERR, 32'h1);
    wr(A_ERR, 32'h3);
  endtask
  // Upper then lower failure, masking, clearing at start
  task t_fail;
    wr(A_LIM_BASE + 8'h10, 32'h0);
    wr(A_EN_BASE + 8'h8, 32'h1);
    wr(A_QMASK, 32'h600);
    pm(1'b1);
    smp(2'h1, 8'h05);
    pm(1'b0);
    rdc("en1", A_EN_BASE + 8'h4, 32'h6);
    rdc("en2", A_EN_BASE + 8'h8, 32'h1);
    rdc("ques", A_QUES, 32'h400);
    wr(A_QMASK, 32'h0);
    rdc("ques", A_QUES, 32'h0);
    wr(A_QMASK, 32'h600);
    pm(1'b1);
    rdc("en1", A_EN_BASE + 8'h4, 32'h2);
    smp(2'h2, 8'hfe);
    smp(2'h1, 8'h03);
    pm(1'b0);
    rdc("en2", A_EN_BASE + 8'h8, 32'h5);
    rdc("en1", A_EN_BASE + 8'h4, 32'h2);
    rdc("ques", A_QUES, 32'h200);
  endtask
  // Abort of continuous measurement and calibration
  task t_abort;
    wr(A_CTRL, 32'h66);
    pm(1'b1);
    @(posedge hclk);
    cal_start <= 1'b1;
    smp(2'h0, 8'h00);
    cal_start <= 1'b0;
    smp(2'h0, 8'h01);
    rdc("stat", A_STAT, 32'hf);
    wr(A_CMD, 32'h1);
    rdc("stat", A_STAT, 32'h0);
    chk("act", {meas_active, cal_active}, 32'h0);
    xfer(1'b0, A_CTRL, 32'h0);
    chk("ctrl", rdv & 32'h3f4, 32'h60);
    rdc("count", A_COUNT, 32'h2);
    rdc("up1", A_LIM_BASE + 8'hc, 32'h3);
    wr(A_CMD, 32'h1);
    rdc("err", A_ERR, 32'h0);
    rdc("count", A_COUNT, 32'h2);
  endtask
  // Trigger conflict and range change
  task t_trig;
    wr(A_CTRL, 32'h3e0);
    wr(A_EN_BASE + 8'hc, 32'h2);
    rdc("en3", A_EN_BASE + 8'hc, 32'h0);
    rdc("err", A_ERR, 32'h2);
    wr(A_CTRL, 32'h40);
    rdc("up1", A_LIM_BASE + 8'hc, 32'h3);
  endtask

  // ************************************************************
  // Clock, watchdog, verdict
  // ************************************************************
  initial
  begin
    forever #25 hclk = ~hclk;
  end
  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #400us;
    mismatches++;
    results;
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_excl;
    t_fail;
    t_abort;
    t_trig;
    results;
  end
endmodule
